// *** verilog/tmc_consts.vh ***
// Purpose: constants shared by the timer main counter files
// Assumes: byte-wide registers, each on its own aligned APB word
// Notes:   offsets are byte addresses on paddr
`ifndef TMC_CONSTS_VH
`define TMC_CONSTS_VH

// register byte addresses
`define TMC_A_STATUS_CTRL 8'h00
`define TMC_A_COUNT_HIGH  8'h04
`define TMC_A_COUNT_LOW   8'h08
`define TMC_A_MOD_HIGH    8'h0C
`define TMC_A_MOD_LOW     8'h10
`define TMC_A_CHAN0_CTRL  8'h14

// timer_status_control fields
`define TMC_SC_OVF        7
`define TMC_SC_IRQ_EN     6
`define TMC_SC_CPWM       5
`define TMC_SC_CLKS_HI    4
`define TMC_SC_CLKS_LO    3
`define TMC_SC_PS_MSB     2
`define TMC_SC_PS_LSB     0

// chan0 control fields
`define TMC_CC_PULLUP     2
`define TMC_CC_ELS_B      1
`define TMC_CC_ELS_A      0

// clock select codes {high, low}
`define TMC_CLK_OFF       2'b00
`define TMC_CLK_BUS       2'b01
`define TMC_CLK_FIXED     2'b10
`define TMC_CLK_EXT       2'b11

// reset values
`define TMC_SC_RST        8'h00
`define TMC_MOD_RST       16'h0000
`define TMC_ELS_RST       2'b00
`define TMC_CNT_ZERO      16'h0000
`define TMC_CNT_ALL_ONES  16'hFFFF
`define TMC_DIV_ZERO      7'h00
`define TMC_RD_ZERO       32'h0000_0000

`endif

// *** verilog/tmc_prescaler.v ***
// Purpose: clock source select, pin clock synchroniser and divider
// Assumes: pin clock slower than a quarter of pclk
// Notes:   tick is a one-cycle strobe that advances the counter
`timescale 1ns/10ps
`include "tmc_consts.vh"

module tmc_prescaler (
  pclk,
  presetn,
  clk_sel,
  ps_sel,
  ext_clk_pin,
  halt,
  clr,
  tick
);
  input  wire       pclk;
  input  wire       presetn;
  input  wire [1:0] clk_sel;
  input  wire [2:0] ps_sel;
  input  wire       ext_clk_pin;
  input  wire       halt;
  input  wire       clr;
  output wire       tick;

  reg        ext_s1_r;
  reg        ext_s2_r;
  reg        ext_s3_r;
  reg  [6:0] div_r;
  reg        src_tick;
  wire [6:0] mask;

  function [6:0] ps_mask;
    input [2:0] ps;
    begin
      case (ps)
        3'd0:    ps_mask = 7'h00;
        3'd1:    ps_mask = 7'h01;
        3'd2:    ps_mask = 7'h03;
        3'd3:    ps_mask = 7'h07;
        3'd4:    ps_mask = 7'h0F;
        3'd5:    ps_mask = 7'h1F;
        3'd6:    ps_mask = 7'h3F;
        default: ps_mask = 7'h7F;
      endcase
    end
  endfunction

  // two-stage synchroniser, third stage only for edge detect
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_s1_r <= 1'b0;
      ext_s2_r <= 1'b0;
      ext_s3_r <= 1'b0;
    end else begin
      ext_s1_r <= ext_clk_pin;
      ext_s2_r <= ext_s1_r;
      ext_s3_r <= ext_s2_r;
    end
  end

  always @* begin
    case (clk_sel)
      `TMC_CLK_BUS:   src_tick = 1'b1;
      `TMC_CLK_FIXED: src_tick = 1'b1;
      `TMC_CLK_EXT:   src_tick = ext_s2_r & ~ext_s3_r;
      default:        src_tick = 1'b0;
    endcase
  end

  assign mask = ps_mask(ps_sel);
  // debug halt freezes the divider as well as the counter
  assign tick = src_tick & ~halt & ((div_r & mask) == mask);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      div_r <= `TMC_DIV_ZERO;
    else if (clr)
      div_r <= `TMC_DIV_ZERO;
    else if (src_tick & ~halt)
      div_r <= div_r + 7'd1;
  end
endmodule // tmc_prescaler

// *** verilog/tmc_timer_main_counter.v ***
// Purpose: 16-bit main time base with prescaler, modulus and APB access
// Assumes: APB slave on pclk, zero wait states, byte registers
// Notes:   counter holds in debug halt
//
// Overview of operation
// - clock select clears to off after reset
// - select bus clock or synced pin clock
// - fixed clock choice runs from bus clock
// - prescaler divides by one to 128
// - pin clock synchronised on bus clock
// - up count zero to terminal, then wrap
// - modulus zero or all ones free-runs
// - center mode counts up then down
// - center select makes all channels center
// - up mode flag on terminal to zero
// - center mode flag on turn from modulus
// - level interrupt while flag and enable
// - counter reads coherent through byte latch
// - counter write clears count and latch
// - debug halt pauses counting
// - timer-owned pin ignores port settings
// - reset leaves pins as GPIO, no pullups
`timescale 1ns/10ps
`include "tmc_consts.vh"

module tmc_timer_main_counter (
  pclk,
  presetn,
  paddr,
  psel,
  penable,
  pwrite,
  pwdata,
  prdata,
  pready,
  pslverr,
  bdm_active,
  pin0_i,
  gpio_dout0,
  gpio_dir0,
  gpio_pu0,
  chan0_drive,
  chan0_out,
  pin0_o,
  pin0_oe,
  pin0_pu_en,
  count_value,
  count_down,
  overflow_pulse,
  center_pwm_select,
  chan0_edge_level,
  timer_active,
  overflow_irq
);
  input  wire        pclk;
  input  wire        presetn;
  input  wire [7:0]  paddr;
  input  wire        psel;
  input  wire        penable;
  input  wire        pwrite;
  input  wire [31:0] pwdata;
  output reg  [31:0] prdata;
  output wire        pready;
  output wire        pslverr;
  input  wire        bdm_active;
  input  wire        pin0_i;
  input  wire        gpio_dout0;
  input  wire        gpio_dir0;
  input  wire        gpio_pu0;
  input  wire        chan0_drive;
  input  wire        chan0_out;
  output wire        pin0_o;
  output wire        pin0_oe;
  output wire        pin0_pu_en;
  output wire [15:0] count_value;
  output wire        count_down;
  output wire        overflow_pulse;
  output wire        center_pwm_select;
  output wire [1:0]  chan0_edge_level;
  output wire        timer_active;
  output wire        overflow_irq;

  // control and status
  reg        ovf_r;
  reg        irq_en_r;
  reg        cpwm_r;
  reg [1:0]  clk_sel_r;
  reg [2:0]  ps_r;
  reg [15:0] mod_r;
  reg [1:0]  els_r;
  reg        tpu_r;

  // counter
  reg [15:0] cnt_r;
  reg [15:0] cnt_nxt;
  reg        down_r;
  reg        down_nxt;
  reg        wrap_nxt;
  reg        ovf_pulse_r;

  // read coherency
  reg [15:0] latch_r;
  reg        latch_vld_r;
  reg        rd_hi_r;
  reg        rd_lo_r;
  reg [15:0] snap_r;

  wire        acc;
  wire        setup;
  wire        wr_acc;
  wire        rd_acc;
  wire        hit;
  wire        cnt_wr;
  wire        rd_hi;
  wire        rd_lo;
  wire        tick;
  wire [15:0] term;
  wire [15:0] cnt_view;
  wire        ext_in;
  wire        chan_pin;
  wire        own;
  reg  [7:0]  rd_byte;

  function addr_ok;
    input [7:0] a;
    begin
      case (a)
        `TMC_A_STATUS_CTRL,
        `TMC_A_COUNT_HIGH,
        `TMC_A_COUNT_LOW,
        `TMC_A_MOD_HIGH,
        `TMC_A_MOD_LOW,
        `TMC_A_CHAN0_CTRL: addr_ok = 1'b1;
        default:           addr_ok = 1'b0;
      endcase
    end
  endfunction

  // ---------------- APB slave ----------------
  // zero wait states: ready in every access cycle
  assign setup   = psel & ~penable;
  assign acc     = psel & penable;
  assign hit     = addr_ok(paddr);
  assign pready  = acc;
  assign pslverr = acc & ~hit;
  assign wr_acc  = acc & pwrite & hit;
  assign rd_acc  = acc & ~pwrite & hit;

  assign cnt_wr = wr_acc & ((paddr == `TMC_A_COUNT_HIGH) |
                            (paddr == `TMC_A_COUNT_LOW));
  assign rd_hi  = rd_acc & (paddr == `TMC_A_COUNT_HIGH);
  assign rd_lo  = rd_acc & (paddr == `TMC_A_COUNT_LOW);

  // a held latch is returned until both bytes were read
  assign cnt_view = latch_vld_r ? latch_r : cnt_r;

  always @* begin
    case (paddr)
      `TMC_A_STATUS_CTRL: rd_byte = {ovf_r, irq_en_r, cpwm_r,
                                     clk_sel_r, ps_r};
      `TMC_A_COUNT_HIGH:  rd_byte = cnt_view[15:8];
      `TMC_A_COUNT_LOW:   rd_byte = cnt_view[7:0];
      `TMC_A_MOD_HIGH:    rd_byte = mod_r[15:8];
      `TMC_A_MOD_LOW:     rd_byte = mod_r[7:0];
      `TMC_A_CHAN0_CTRL:  rd_byte = {5'b00000, tpu_r, els_r};
      default:            rd_byte = 8'h00;
    endcase
  end

  // read data is sampled in the setup cycle, ready in the access cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= `TMC_RD_ZERO;
      snap_r <= `TMC_CNT_ZERO;
    end else if (setup) begin
      prdata <= {24'h00_0000, rd_byte};
      snap_r <= cnt_r;
    end
  end

  // ---------------- control registers ----------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_en_r  <= 1'b0;
      cpwm_r    <= 1'b0;
      clk_sel_r <= `TMC_CLK_OFF;
      ps_r      <= 3'b000;
      mod_r     <= `TMC_MOD_RST;
      els_r     <= `TMC_ELS_RST;
      tpu_r     <= 1'b0;
    end else if (wr_acc) begin
      case (paddr)
        `TMC_A_STATUS_CTRL: begin
          irq_en_r  <= pwdata[`TMC_SC_IRQ_EN];
          cpwm_r    <= pwdata[`TMC_SC_CPWM];
          clk_sel_r <= {pwdata[`TMC_SC_CLKS_HI], pwdata[`TMC_SC_CLKS_LO]};
          ps_r      <= pwdata[`TMC_SC_PS_MSB:`TMC_SC_PS_LSB];
        end
        `TMC_A_MOD_HIGH: mod_r[15:8] <= pwdata[7:0];
        `TMC_A_MOD_LOW:  mod_r[7:0]  <= pwdata[7:0];
        `TMC_A_CHAN0_CTRL: begin
          tpu_r <= pwdata[`TMC_CC_PULLUP];
          els_r <= {pwdata[`TMC_CC_ELS_B], pwdata[`TMC_CC_ELS_A]};
        end
        default: ;
      endcase
    end
  end

  // ---------------- clock source and prescaler ----------------
  tmc_prescaler u_prescaler (
    .pclk        (pclk),
    .presetn     (presetn),
    .clk_sel     (clk_sel_r),
    .ps_sel      (ps_r),
    .ext_clk_pin (pin0_i),
    .halt        (bdm_active),
    .clr         (cnt_wr),
    .tick        (tick)
  );

  // ---------------- counter ----------------
  // modulus of zero or all ones gives the full range
  assign term = ((mod_r == `TMC_CNT_ZERO) | (mod_r == `TMC_CNT_ALL_ONES))
                ? `TMC_CNT_ALL_ONES : mod_r;

  always @* begin
    cnt_nxt  = cnt_r;
    down_nxt = down_r;
    wrap_nxt = 1'b0;
    if (!cpwm_r) begin
      down_nxt = 1'b0;
      if (cnt_r == term) begin
        cnt_nxt  = `TMC_CNT_ZERO;
        wrap_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r + 16'h0001;
      end
    end else if (!down_r) begin
      if (cnt_r == term) begin
        // terminal count lasts one tick, then the turn
        cnt_nxt  = cnt_r - 16'h0001;
        down_nxt = 1'b1;
        wrap_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r + 16'h0001;
      end
    end else begin
      if (cnt_r == `TMC_CNT_ZERO) begin
        cnt_nxt  = cnt_r + 16'h0001;
        down_nxt = 1'b0;
      end else begin
        cnt_nxt = cnt_r - 16'h0001;
      end
    end
  end

  // a counter write wins over a tick in the same cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r       <= `TMC_CNT_ZERO;
      down_r      <= 1'b0;
      ovf_pulse_r <= 1'b0;
    end else if (cnt_wr) begin
      cnt_r       <= `TMC_CNT_ZERO;
      down_r      <= 1'b0;
      ovf_pulse_r <= 1'b0;
    end else if (tick) begin
      cnt_r       <= cnt_nxt;
      down_r      <= down_nxt;
      ovf_pulse_r <= wrap_nxt;
    end else begin
      ovf_pulse_r <= 1'b0;
    end
  end

  // ---------------- overflow flag ----------------
  // write one to the flag bit clears it; a new overflow wins
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      ovf_r <= 1'b0;
    else if (tick & wrap_nxt & ~cnt_wr)
      ovf_r <= 1'b1;
    else if (wr_acc & (paddr == `TMC_A_STATUS_CTRL) &
             pwdata[`TMC_SC_OVF])
      ovf_r <= 1'b0;
  end

  // level request for as long as the flag stays set
  assign overflow_irq = ovf_r & irq_en_r;

  // ---------------- read coherency latch ----------------
  // snap_r holds the count seen in the read's setup cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      latch_r     <= `TMC_CNT_ZERO;
      latch_vld_r <= 1'b0;
      rd_hi_r     <= 1'b0;
      rd_lo_r     <= 1'b0;
    end else if (cnt_wr) begin
      latch_vld_r <= 1'b0;
      rd_hi_r     <= 1'b0;
      rd_lo_r     <= 1'b0;
    end else if (rd_hi | rd_lo) begin
      if ((rd_hi | rd_hi_r) & (rd_lo | rd_lo_r)) begin
        // both halves seen: release the latch
        latch_vld_r <= 1'b0;
        rd_hi_r     <= 1'b0;
        rd_lo_r     <= 1'b0;
      end else begin
        if (!latch_vld_r)
          latch_r <= snap_r;
        latch_vld_r <= 1'b1;
        rd_hi_r     <= rd_hi | rd_hi_r;
        rd_lo_r     <= rd_lo | rd_lo_r;
      end
    end
  end

  // ---------------- pin ownership ----------------
  // timer pullup acts only while the pin is not driven
  // pin clock takes the pin as an input even if channel bits are left set
  assign ext_in   = (clk_sel_r == `TMC_CLK_EXT);
  assign chan_pin = (els_r != 2'b00) & ~ext_in;
  assign own      = ext_in | chan_pin;

  assign pin0_oe    = own ? (chan_pin & chan0_drive) : gpio_dir0;
  assign pin0_o     = own ? chan0_out : gpio_dout0;
  assign pin0_pu_en = own ? (tpu_r & ~pin0_oe)
                          : (gpio_pu0 & ~gpio_dir0);

  // ---------------- outputs to channel logic ----------------
  assign count_value       = cnt_r;
  assign count_down        = down_r;
  assign overflow_pulse    = ovf_pulse_r;
  assign center_pwm_select = cpwm_r;
  assign chan0_edge_level  = els_r;
  assign timer_active      = (clk_sel_r != `TMC_CLK_OFF);

endmodule // tmc_timer_main_counter

// *** tb/tmc_timer_main_counter_monitor.sv ***
// Purpose: port checker for the timer main counter
// Assumes: bound to the top module, single pclk domain
// Notes:   APB answers with zero wait states
`timescale 1ns/10ps
`include "tmc_consts.vh"

module tmc_monitor (
  input logic        pclk,
  input logic        presetn,
  input logic [7:0]  paddr,
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic        pready,
  input logic        pslverr,
  input logic        bdm_active,
  input logic        gpio_dout0,
  input logic        gpio_dir0,
  input logic        pin0_o,
  input logic        pin0_oe,
  input logic [15:0] count_value,
  input logic        count_down,
  input logic        overflow_pulse,
  input logic        center_pwm_select,
  input logic [1:0]  chan0_edge_level,
  input logic        timer_active,
  input logic        overflow_irq
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  wire acc    = psel && penable;
  wire sc_wr  = acc && pwrite && paddr == `TMC_A_STATUS_CTRL;
  wire cnt_wr = acc && pwrite && (paddr == `TMC_A_COUNT_HIGH ||
                                  paddr == `TMC_A_COUNT_LOW);

  sequence setup_s;
    psel && !penable;
  endsequence
  sequence access_s;
    psel && penable;
  endsequence

  ready_access_a: assert property (setup_s ##1 access_s |-> pready)
    else $error("no ready in access");
  err_map_a: assert property (access_s |->
    pslverr == (paddr > 8'h14 || paddr[1:0] != 2'b00))
    else $error("slave error mismatch");
  cnt_clear_a: assert property (
    cnt_wr |=> count_value == 16'h0000)
    else $error("count not cleared");
  halt_hold_a: assert property (
    bdm_active && !psel |=> $stable(count_value))
    else $error("count moved in halt");
  off_hold_a: assert property (
    !timer_active && !psel |=> $stable(count_value))
    else $error("count moved while off");
  ovf_up_zero_a: assert property (
    overflow_pulse && !center_pwm_select |-> count_value == 16'h0000)
    else $error("up overflow not at zero");
  ovf_center_a: assert property (
    overflow_pulse && center_pwm_select |->
    count_down && count_value == $past(count_value) - 16'h0001)
    else $error("center overflow misplaced");
  irq_rise_a: assert property (
    $rose(overflow_irq) |-> overflow_pulse || $past(sc_wr))
    else $error("irq rose without cause");
  irq_fall_a: assert property (
    $fell(overflow_irq) |-> $past(sc_wr))
    else $error("irq fell without clear");
  gpio_own_a: assert property (
    chan0_edge_level == 2'b00 && !timer_active |->
    pin0_oe == gpio_dir0 && pin0_o == gpio_dout0)
    else $error("pin not under port control");
endmodule // tmc_monitor

// *** tb/tb_tmc_timer_main_counter.sv ***
// Purpose: directed bench for the timer main counter over APB
// Assumes: zero wait state slave, bus clock 200 MHz
// Notes:   port pin controls and channel drive set by the bench
`timescale 1ns/10ps
`include "tmc_consts.vh"
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin fails++; \
  $display("ERROR t=%0t got %h exp %h", $time, a, e); end end

module tb_tmc_timer_main_counter;
  localparam logic [7:0] A_SC = `TMC_A_STATUS_CTRL;
  localparam logic [7:0] A_CH = `TMC_A_COUNT_HIGH;
  localparam logic [7:0] A_CL = `TMC_A_COUNT_LOW;
  localparam logic [7:0] A_ML = `TMC_A_MOD_LOW;
  localparam logic [7:0] A_C0 = `TMC_A_CHAN0_CTRL;
  logic        pclk, presetn, psel, penable, pwrite, bdm_active, pin0_i;
  logic        gpio_dout0, gpio_dir0, gpio_pu0, chan0_drive;
  logic [7:0]  paddr, r;
  logic [31:0] pwdata;
  logic [15:0] v;
  logic [15:0] cs [6] = '{16'h0001, 16'h0000, 16'h0001, 16'h0002,
                          16'h0003, 16'h0002};
  wire  [31:0] prdata;
  wire  [15:0] count_value;
  wire  [1:0]  chan0_edge_level;
  wire         pready, pslverr, pin0_o, pin0_oe, pin0_pu_en, count_down;
  wire         overflow_pulse, center_pwm_select, timer_active;
  wire         overflow_irq;
  int          fails = 0, checks = 0, n, g;

  tmc_timer_main_counter DUT (.pclk(pclk), .presetn(presetn),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .bdm_active(bdm_active), .pin0_i(pin0_i), .gpio_dout0(gpio_dout0),
    .gpio_dir0(gpio_dir0), .gpio_pu0(gpio_pu0), .chan0_drive(chan0_drive),
    .chan0_out(1'b1), .pin0_o(pin0_o), .pin0_oe(pin0_oe),
    .pin0_pu_en(pin0_pu_en), .count_value(count_value),
    .count_down(count_down), .overflow_pulse(overflow_pulse),
    .center_pwm_select(center_pwm_select),
    .chan0_edge_level(chan0_edge_level), .timer_active(timer_active),
    .overflow_irq(overflow_irq));

  always #2.5 pclk = ~pclk;

  task automatic end_of_test;
    if (fails == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic apb(input logic [7:0] a, input logic w,
                     input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= {24'h00_0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (n == 50) begin fails++; end_of_test; end
    r = prdata[7:0];
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic waitp(input int lim);
    for (n = 0; n < lim; n++) begin
      @(posedge pclk);
      if (overflow_pulse === 1'b1) break;
    end
    if (n == lim) begin fails++; end_of_test; end
  endtask

  // edges until the count next changes
  task automatic step;
    v = count_value;
    for (g = 1; g < 300; g++) begin
      @(posedge pclk);
      if (count_value !== v) break;
    end
    if (g == 300) begin fails++; end_of_test; end
  endtask

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, bdm_active, pin0_i} = 5'h00;
    {gpio_dout0, gpio_dir0, gpio_pu0, chan0_drive} = 4'b0101;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(A_SC, 0, 8'h00);
    `CHK(r, 8'h00)
    `CHK({timer_active, pin0_oe, pin0_o, pin0_pu_en}, 4'h4)
    repeat (20) @(posedge pclk);
    `CHK(count_value, 16'h0000)
    apb(8'h18, 1, 8'hFF);
    for (int k = 0; k < 9; k++) begin
      apb(A_SC, 1, k < 8 ? 8'h08 | 8'(k) : 8'h10);
      step;
      step;
      step;
      `CHK(g, 1 << (k % 8))
    end
    apb(A_C0, 1, 8'h00);
    apb(A_SC, 1, 8'h18);
    apb(A_CL, 1, 8'h5A);
    repeat (5) begin
      repeat (4) @(posedge pclk);
      pin0_i <= 1'b1;
      repeat (4) @(posedge pclk);
      pin0_i <= 1'b0;
    end
    repeat (8) @(posedge pclk);
    `CHK(count_value, 16'h0005)
    apb(A_SC, 1, 8'h08);
    apb(A_CL, 1, 8'h00);
    apb(A_CL, 0, 8'h00);
    repeat (300) @(posedge pclk);
    apb(A_CH, 0, 8'h00);
    `CHK(r, 8'h00)
    apb(A_CL, 0, 8'h00);
    apb(A_CH, 0, 8'h00);
    `CHK(r, 8'h01)
    apb(A_CL, 1, 8'h00);
    apb(A_CL, 0, 8'h00);
    repeat (300) @(posedge pclk);
    apb(A_CH, 1, 8'hFF);
    repeat (300) @(posedge pclk);
    apb(A_CH, 0, 8'h00);
    `CHK(r, 8'h01)
    apb(A_ML, 1, 8'h05);
    apb(A_CL, 1, 8'h00);
    apb(A_SC, 1, 8'h48);
    waitp(100);
    for (int i = 1; i < 7; i++) begin
      @(posedge pclk);
      `CHK(count_value, 16'(i % 6))
    end
    `CHK(overflow_irq, 1'b1)
    apb(A_SC, 0, 8'h00);
    `CHK(r[7], 1'b1)
    apb(A_SC, 1, 8'h40);
    repeat (20) @(posedge pclk);
    `CHK(overflow_irq, 1'b1)
    apb(A_SC, 1, 8'hC0);
    @(posedge pclk);
    `CHK(overflow_irq, 1'b0)
    apb(A_SC, 1, 8'h08);
    waitp(100);
    @(posedge pclk);
    `CHK(overflow_irq, 1'b0)
    apb(A_SC, 1, 8'h00);
    apb(A_ML, 1, 8'h03);
    apb(A_CL, 1, 8'h00);
    apb(A_SC, 1, 8'h28);
    waitp(100);
    `CHK({count_down, count_value}, 17'h1_0002)
    `CHK(center_pwm_select, 1'b1)
    for (int i = 0; i < 6; i++) begin
      @(posedge pclk);
      `CHK(count_value, cs[i])
    end
    bdm_active <= 1'b1;
    @(posedge pclk);
    v = count_value;
    repeat (10) @(posedge pclk);
    `CHK(count_value, v)
    bdm_active <= 1'b0;
    step;
    `CHK(g, 2)
    gpio_dir0 <= 1'b0;
    apb(A_C0, 1, 8'h05);
    @(posedge pclk);
    `CHK({chan0_edge_level, pin0_oe, pin0_o, pin0_pu_en}, 5'h0E)
    chan0_drive <= 1'b0;
    @(posedge pclk);
    `CHK({pin0_oe, pin0_o, pin0_pu_en}, 3'b011)
    gpio_pu0 <= 1'b1;
    apb(A_C0, 1, 8'h00);
    @(posedge pclk);
    `CHK({pin0_oe, pin0_o, pin0_pu_en}, 3'b001)
    end_of_test;
  end
endmodule // tb_tmc_timer_main_counter

bind tmc_timer_main_counter tmc_monitor u_mon (.pclk(pclk),
  .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pready(pready), .pslverr(pslverr),
  .bdm_active(bdm_active), .gpio_dout0(gpio_dout0),
  .gpio_dir0(gpio_dir0), .pin0_o(pin0_o), .pin0_oe(pin0_oe),
  .count_value(count_value), .count_down(count_down),
  .overflow_pulse(overflow_pulse), .center_pwm_select(center_pwm_select),
  .chan0_edge_level(chan0_edge_level), .timer_active(timer_active),
  .overflow_irq(overflow_irq));
